// >>> design/fsp_device.sv
// device end: protection and learning pattern
// Notes on behaviour
// RQ1: persistent byte reads 00 protected, FF free
// RQ2: dynamic byte resets FF; 00 protects, FF frees
// RQ3: persistent read FC/E2, program FD/E3, erase E4
// RQ4: dynamic read FA/E0, write FB/E1
// RQ5: pattern read 41, program 43, write 4A
// RQ6: stored and active patterns, factory 00
// RQ7: programming stored pattern also loads active
// RQ8: active writable anytime, reloaded at reset
// RQ9: pattern driven in training read dummy cycles
// RQ10: driven pattern comes from active register
// RQ11: write-protect pin guards BP, lock, QE
// RQ12: status locked only when lock=1, pin low
// RQ13: modifying commands need write enable latch; active pattern write (4A) is accepted without it
// RQ14: block protection active when any BP set
// RQ15: sector protected by block OR sector scheme
// RQ16: host should use only one scheme
// RQ17: persistent or dynamic bit 0 blocks writes
// RQ18: persistent bits frozen while lock bit 0
// RQ19: program one persistent bit, erase all
// RQ20: wide opcodes take four address bytes
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "fsp_params.svh"
module fsp_device import fsp_pkg::*; (
    // clock and reset
    input  wire logic       CLOCK,
    input  wire logic       RESETN,
    // serial link
    fsp_link_if.dev         link,
    // protection configuration
    input  wire logic       PROTECT_LOCK,
    input  wire logic       ADDR_WIDE,
    // state and events
    output logic [7:0]      STATUS_REG,
    output logic [7:0]      ACTIVE_PATTERN,
    output logic            OP_GRANT,
    output logic            OP_DENY,
    output logic [3:0]      OP_SECTOR
);

    // ==========================================
    // helpers
    function automatic logic has_addr(input logic [7:0] op);
        return op inside {`FSP_OP_PROG, `FSP_OP_ERASE, `FSP_OP_TRAIN_READ, `FSP_OP_RD_PERS,
                          `FSP_OP_RD_PERS_W, `FSP_OP_PG_PERS, `FSP_OP_PG_PERS_W, `FSP_OP_RD_DYN,
                          `FSP_OP_RD_DYN_W, `FSP_OP_WR_DYN, `FSP_OP_WR_DYN_W}; // RQ3 RQ4
    endfunction

    function automatic logic is_wide(input logic [7:0] op);
        return op inside {`FSP_OP_RD_PERS_W, `FSP_OP_PG_PERS_W, `FSP_OP_RD_DYN_W, `FSP_OP_WR_DYN_W};
    endfunction

    function automatic logic [3:0] sector_of(input logic [31:0] a);
        return a[`FSP_SEC_LSB +: 4];
    endfunction

    // top-down block range
    function automatic logic bp_covers(input logic [3:0] bp, input logic [3:0] s);
        logic [4:0] span;
        span = (bp > 4'h5) ? `FSP_SECTORS : 5'(5'h01 << (bp - 4'h1));
        return (bp != 4'h0) && ({1'b0, s} >= (`FSP_SECTORS - span)); // RQ14
    endfunction

    // ==========================================
    // pin synchronisers
    logic sclk_m, sclk_s, sclk_d;
    logic cs_m, cs_s, cs_d;
    logic mosi_m, mosi_s;
    logic wp_m, wp_s;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            {sclk_m, sclk_s, sclk_d} <= 3'h0;
            {cs_m, cs_s, cs_d} <= 3'h7;
            {mosi_m, mosi_s} <= 2'h0;
            {wp_m, wp_s} <= 2'h3;
        end else begin
            {sclk_m, sclk_s, sclk_d} <= {link.sclk, sclk_m, sclk_s};
            {cs_m, cs_s, cs_d} <= {link.cs_n, cs_m, cs_s};
            {mosi_m, mosi_s} <= {link.mosi, mosi_m};
            {wp_m, wp_s} <= {link.wp_n, wp_m};
        end
    end

    // ==========================================
    // state
    fsp_phase_e  phase;
    logic [6:0]  rx_sh;
    logic [2:0]  bit_cnt;
    logic [1:0]  abytes;
    logic [7:0]  opcode;
    logic [31:0] addr;
    logic [7:0]  din;
    logic        din_ok;
    logic [7:0]  tx_sh;
    logic        miso;
    logic        miso_oe;
    logic        write_enable_latch;
    logic [3:0]  bp;
    logic        qe;
    logic        status_write_lock;
    logic [15:0] pers;
    logic [15:0] dyn;
    logic [7:0]  stored;
    logic [7:0]  active;
    logic        reload;

    // ==========================================
    // receive decode
    wire         sclk_rise = sclk_s & ~sclk_d & ~cs_s;
    wire         sclk_fall = ~sclk_s & sclk_d & ~cs_s;
    wire         cs_start  = ~cs_s & cs_d;
    wire         cs_end    = cs_s & ~cs_d;
    wire [7:0]   rx_full   = {rx_sh, mosi_s};
    wire         byte_done = sclk_rise & (bit_cnt == 3'h7);
    wire [1:0]   last_ab   = (is_wide(opcode) | ADDR_WIDE) ? 2'h3 : 2'h2; // RQ20
    wire         addr_last = (phase == PH_ADDR) & (abytes == last_ab);
    wire [31:0]  next_addr = (phase == PH_ADDR) ? {addr[23:0], rx_full} : addr;
    wire [7:0]   next_op   = (phase == PH_OP) ? rx_full : opcode;

    fsp_phase_e next_phase;
    always_comb begin
        next_phase = phase;
        unique case (phase)
            PH_OP:    next_phase = has_addr(rx_full) ? PH_ADDR : PH_DATA;
            PH_ADDR:  next_phase = addr_last ? ((opcode == `FSP_OP_TRAIN_READ) ? PH_DUMMY : PH_DATA) : PH_ADDR;
            PH_DUMMY: next_phase = PH_DATA;
            PH_DATA:  next_phase = PH_DATA;
        endcase
    end

    // ==========================================
    // answer byte
    wire [3:0]   rsec      = sector_of(next_addr);
    wire [7:0]   status    = {status_write_lock, qe, bp, write_enable_latch, 1'b0};
    logic [7:0]  resp;
    always_comb begin
        unique case (next_op)
            `FSP_OP_RDSR:                          resp = status;
            `FSP_OP_RD_PERS, `FSP_OP_RD_PERS_W:    resp = pers[rsec] ? `FSP_UNPROTECTED : `FSP_PROTECTED; // RQ1
            `FSP_OP_RD_DYN, `FSP_OP_RD_DYN_W:      resp = dyn[rsec] ? `FSP_UNPROTECTED : `FSP_PROTECTED;  // RQ2
            `FSP_OP_RD_PAT:                        resp = active; // RQ5
            `FSP_OP_TRAIN_READ:                    resp = `FSP_ERASED_DATA;
            default:                               resp = 8'h00;
        endcase
    end
    wire [7:0]   tx_next   = (next_phase == PH_DUMMY) ? active :           // RQ9 RQ10
                             (next_phase == PH_DATA && phase != PH_OP) ? resp :
                             (next_phase == PH_DATA && !has_addr(rx_full)) ? resp : 8'h00;

    // ==========================================
    // frame shifting
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            phase   <= PH_OP;
            rx_sh   <= 7'h00;
            bit_cnt <= 3'h0;
            abytes  <= 2'h0;
            opcode  <= 8'h00;
            addr    <= 32'h0;
            din     <= 8'h00;
            din_ok  <= 1'b0;
            tx_sh   <= 8'h00;
        end else if (cs_start) begin
            phase   <= PH_OP;
            bit_cnt <= 3'h0;
            abytes  <= 2'h0;
            din_ok  <= 1'b0;
            tx_sh   <= 8'h00;
        end else if (sclk_rise) begin
            rx_sh   <= rx_full[6:0];
            bit_cnt <= bit_cnt + 3'h1;
            tx_sh   <= byte_done ? tx_next : {tx_sh[6:0], 1'b0};
            if (byte_done) begin
                phase  <= next_phase;
                opcode <= next_op;
                addr   <= next_addr;
                abytes <= (phase == PH_ADDR) ? abytes + 2'h1 : abytes;
                if (phase == PH_DATA && !din_ok) begin
                    din    <= rx_full;
                    din_ok <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            miso    <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= ~cs_s;
            if (sclk_fall) begin
                miso <= tx_sh[7];
            end
        end
    end

    assign link.miso    = miso;
    assign link.miso_oe = miso_oe;

    // ==========================================
    // execution at deselect
    wire         whole     = cs_end & (bit_cnt == 3'h0) & (phase == PH_DATA);
    wire [3:0]   esec      = sector_of(addr);
    wire         sr_locked = status_write_lock & ~wp_s;                                  // RQ11 RQ12
    wire         do_wrsr   = whole & din_ok & write_enable_latch & (opcode == `FSP_OP_WRSR); // RQ13
    wire         pers_ok   = whole & write_enable_latch & PROTECT_LOCK;                    // RQ18
    wire         do_pgpers = pers_ok & (opcode inside {`FSP_OP_PG_PERS, `FSP_OP_PG_PERS_W});
    wire         do_erpers = pers_ok & (opcode == `FSP_OP_ER_PERS);
    wire         do_wrdyn  = whole & din_ok & write_enable_latch & (opcode inside {`FSP_OP_WR_DYN, `FSP_OP_WR_DYN_W});
    wire         do_stored = whole & din_ok & write_enable_latch & (opcode == `FSP_OP_PG_STORED);
    wire         do_active = whole & din_ok & (opcode == `FSP_OP_WR_ACTIVE);
    wire         do_array  = whole & write_enable_latch & (opcode inside {`FSP_OP_PROG, `FSP_OP_ERASE});
    wire         sec_prot  = ~pers[esec] | ~dyn[esec] | bp_covers(bp, esec); // RQ15 RQ17
    wire         clr_wel   = whole & (opcode inside {`FSP_OP_WRDI, `FSP_OP_WRSR, `FSP_OP_PROG, `FSP_OP_ERASE,
                             `FSP_OP_PG_PERS, `FSP_OP_PG_PERS_W, `FSP_OP_ER_PERS, `FSP_OP_WR_DYN,
                             `FSP_OP_WR_DYN_W, `FSP_OP_PG_STORED});

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            write_enable_latch  <= 1'b0;
            bp   <= 4'h0;
            qe   <= 1'b0;
            status_write_lock <= 1'b0;
        end else begin
            if (whole && opcode == `FSP_OP_WRITE_ENABLE_CMD) begin
                write_enable_latch <= 1'b1;
            end else if (clr_wel) begin
                write_enable_latch <= 1'b0; // RQ13
            end
            if (do_wrsr && !sr_locked) begin
                bp   <= din[`FSP_ST_BP_LSB +: 4]; // RQ12
                qe   <= din[`FSP_ST_QE];
                status_write_lock <= din[`FSP_ST_STATUS_WRITE_LOCK];
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            pers <= '1;
            dyn  <= '1; // RQ2
        end else begin
            if (do_erpers) begin
                pers <= '1; // RQ19
            end else if (do_pgpers) begin
                pers[esec] <= 1'b0; // RQ1 RQ19
            end
            if (do_wrdyn && din == `FSP_PROTECTED) begin
                dyn[esec] <= 1'b0; // RQ2
            end else if (do_wrdyn && din == `FSP_UNPROTECTED) begin
                dyn[esec] <= 1'b1;
            end
        end
    end

    // active reloads from stored after reset
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            stored <= `FSP_PATTERN_FACTORY; // RQ6
            active <= `FSP_PATTERN_FACTORY;
            reload <= 1'b1;
        end else begin
            reload <= 1'b0;
            if (reload) begin
                active <= stored; // RQ8
            end else if (do_stored) begin
                stored <= din;
                active <= din; // RQ7
            end else if (do_active) begin
                active <= din; // RQ8
            end
        end
    end

    // ==========================================
    // outputs
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            STATUS_REG     <= 8'h00;
            ACTIVE_PATTERN <= `FSP_PATTERN_FACTORY;
            OP_GRANT       <= 1'b0;
            OP_DENY        <= 1'b0;
            OP_SECTOR      <= 4'h0;
        end else begin
            STATUS_REG     <= status;
            ACTIVE_PATTERN <= active;
            OP_GRANT       <= do_array & ~sec_prot;
            OP_DENY        <= do_array & sec_prot; // RQ17
            if (do_array) begin
                OP_SECTOR <= esec;
            end
        end
    end

endmodule

// >>> design/fsp_params.svh
// constants for the sector protection and learning pattern link
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// ==========================================
// link opcodes
`define FSP_OP_WRITE_ENABLE_CMD         8'h06
`define FSP_OP_WRDI         8'h04
`define FSP_OP_RDSR         8'h05
`define FSP_OP_WRSR         8'h01
`define FSP_OP_PROG         8'h02
`define FSP_OP_ERASE        8'h20
`define FSP_OP_TRAIN_READ   8'h0d
`define FSP_OP_RD_PERS      8'hfc
`define FSP_OP_RD_PERS_W    8'he2
`define FSP_OP_PG_PERS      8'hfd
`define FSP_OP_PG_PERS_W    8'he3
`define FSP_OP_ER_PERS      8'he4
`define FSP_OP_RD_DYN       8'hfa
`define FSP_OP_RD_DYN_W     8'he0
`define FSP_OP_WR_DYN       8'hfb
`define FSP_OP_WR_DYN_W     8'he1
`define FSP_OP_RD_PAT       8'h41
`define FSP_OP_PG_STORED    8'h43
`define FSP_OP_WR_ACTIVE    8'h4a

// ==========================================
// protection byte values and resets
`define FSP_PROTECTED       8'h00
`define FSP_UNPROTECTED     8'hff
`define FSP_PATTERN_FACTORY 8'h00
`define FSP_ERASED_DATA     8'hff

// ==========================================
// status register fields
`define FSP_ST_WEL          1
`define FSP_ST_BP_LSB       2
`define FSP_ST_QE           6
`define FSP_ST_STATUS_WRITE_LOCK         7

// ==========================================
// sector map
`define FSP_SECTORS         5'h10
`define FSP_SEC_LSB         16

// ==========================================
// host registers
`define FSP_REG_CMD         8'h00
`define FSP_REG_ADDR        8'h04
`define FSP_REG_DATA        8'h08
`define FSP_REG_STATUS      8'h0c
`define FSP_REG_CONFIG      8'h10
`define FSP_CMD_ADDR        8
`define FSP_CMD_WIDE        9
`define FSP_CMD_DUMMY       10
`define FSP_CMD_WR          11
`define FSP_CMD_RD          12
`define FSP_RESP_OKAY       2'h0
`define FSP_RESP_SLVERR     2'h2

// ==========================================
// link timing
`define FSP_CLK_PERIOD_NS   10
`define FSP_LINK_HALF_NS    80
`define FSP_HALF_CYC        ((`FSP_LINK_HALF_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)

`endif

// >>> design/fsp_pkg.sv
// types shared by both ends of the protection link
package fsp_pkg;
    typedef enum logic [1:0] {PH_OP, PH_ADDR, PH_DUMMY, PH_DATA} fsp_phase_e;
    typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP} fsp_hstate_e;
endpackage

// >>> design/fsp_link_if.sv
// serial link between the protection controller and the device
`timescale 1ns/1ps
interface fsp_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic wp_n;
    logic miso;
    logic miso_oe;

    modport dev (input sclk, input cs_n, input mosi, input wp_n, output miso, output miso_oe);
    modport host (output sclk, output cs_n, output mosi, output wp_n, input miso);
endinterface

// >>> design/fsp_host.sv
// host end: AXI4-Lite command registers driving the serial link
`timescale 1ns/1ps
`include "fsp_params.svh"
module fsp_host import fsp_pkg::*; (
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESETN,
    // register bus write
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // register bus read
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // serial link
    fsp_link_if.host         link
);

    // ==========================================
    // registers
    logic [12:0] cmd;
    logic [31:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        busy;
    logic        wp_level;
    logic        miso_m, miso_s;
    fsp_hstate_e state;
    logic [3:0]  div;
    logic [2:0]  idx;
    logic [2:0]  bit_cnt;
    logic [7:0]  sh;
    logic [7:0]  rx;
    logic        sclk, cs_n, mosi;

    // ==========================================
    // byte sequence
    wire [2:0]   nab     = cmd[`FSP_CMD_ADDR] ? (cmd[`FSP_CMD_WIDE] ? 3'h4 : 3'h3) : 3'h0;
    wire [2:0]   wr_idx  = nab + 3'h1 + {2'h0, cmd[`FSP_CMD_DUMMY]};
    wire [2:0]   last    = wr_idx + {2'h0, cmd[`FSP_CMD_WR]} + {2'h0, cmd[`FSP_CMD_RD]} - 3'h1;
    wire         half    = div == 4'(`FSP_HALF_CYC - 1);

    function automatic logic [7:0] byte_at(input logic [2:0] i);
        logic [4:0] sft;
        sft = {2'(nab - i), 3'h0};
        if (i == 3'h0)
            return cmd[7:0];
        else if (i <= nab)
            return 8'(addr >> sft);
        else if (i == wr_idx && cmd[`FSP_CMD_WR])
            return wdata;
        else
            return 8'h00;
    endfunction

    wire [7:0]   nxt_byte = byte_at(idx + 3'h1);

    // ==========================================
    // register bus slave
    wire         wr_go   = AWVALID & WVALID & ~BVALID & ~AWREADY;
    wire         rd_go   = ARVALID & ~RVALID & ~ARREADY;
    wire         wr_cmd  = wr_go & (AWADDR == `FSP_REG_CMD) & ~busy;
    wire         wr_map  = AWADDR inside {`FSP_REG_CMD, `FSP_REG_ADDR, `FSP_REG_DATA, `FSP_REG_STATUS, `FSP_REG_CONFIG};
    wire         rd_map  = ARADDR inside {`FSP_REG_CMD, `FSP_REG_ADDR, `FSP_REG_DATA, `FSP_REG_STATUS, `FSP_REG_CONFIG};
    logic [31:0] rd_val;
    always_comb begin
        unique case (ARADDR)
            `FSP_REG_CMD:    rd_val = {19'h0, cmd};
            `FSP_REG_ADDR:   rd_val = addr;
            `FSP_REG_DATA:   rd_val = {24'h0, rdata};
            `FSP_REG_STATUS: rd_val = {31'h0, busy};
            `FSP_REG_CONFIG: rd_val = {31'h0, wp_level};
            default:         rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            AWREADY <= 1'b0;
            WREADY  <= 1'b0;
            BVALID  <= 1'b0;
            BRESP   <= `FSP_RESP_OKAY;
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RRESP   <= `FSP_RESP_OKAY;
            RDATA   <= 32'h0;
        end else begin
            AWREADY <= wr_go;
            WREADY  <= wr_go;
            ARREADY <= rd_go;
            if (wr_go) begin
                BVALID <= 1'b1;
                BRESP  <= wr_map ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
            end else if (BREADY) begin
                BVALID <= 1'b0;
            end
            if (rd_go) begin
                RVALID <= 1'b1;
                RDATA  <= rd_val;
                RRESP  <= rd_map ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
            end else if (RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            cmd      <= 13'h0;
            addr     <= 32'h0;
            wdata    <= 8'h00;
            wp_level <= 1'b1;
        end else if (wr_go && !busy && WSTRB[0]) begin
            unique case (AWADDR)
                `FSP_REG_CMD:    cmd      <= WDATA[12:0];
                `FSP_REG_ADDR:   addr     <= WDATA;
                `FSP_REG_DATA:   wdata    <= WDATA[7:0];
                `FSP_REG_CONFIG: wp_level <= WDATA[0];
                default:         ;
            endcase
        end
    end

    // ==========================================
    // link engine, mode 0, msb first
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            {miso_m, miso_s} <= 2'h0;
        end else begin
            {miso_m, miso_s} <= {link.miso, miso_m};
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state   <= HS_IDLE;
            busy    <= 1'b0;
            div     <= 4'h0;
            idx     <= 3'h0;
            bit_cnt <= 3'h0;
            sh      <= 8'h00;
            rx      <= 8'h00;
            rdata   <= 8'h00;
            sclk    <= 1'b0;
            cs_n    <= 1'b1;
            mosi    <= 1'b0;
        end else begin
            div <= (state == HS_IDLE || half) ? 4'h0 : div + 4'h1;
            unique case (state)
                HS_IDLE: if (wr_cmd) begin
                    busy    <= 1'b1;
                    cs_n    <= 1'b0;
                    idx     <= 3'h0;
                    bit_cnt <= 3'h0;
                    sh      <= WDATA[7:0];
                    mosi    <= WDATA[7];
                    state   <= HS_LOW;
                end
                HS_LOW: if (half) begin
                    sclk  <= 1'b1;
                    rx    <= {rx[6:0], miso_s};
                    state <= HS_HIGH;
                end
                HS_HIGH: if (half) begin
                    sclk    <= 1'b0;
                    bit_cnt <= bit_cnt + 3'h1;
                    state   <= HS_LOW;
                    if (bit_cnt != 3'h7) begin
                        sh   <= {sh[6:0], 1'b0};
                        mosi <= sh[6];
                    end else if (idx != last) begin
                        idx  <= idx + 3'h1;
                        sh   <= nxt_byte;
                        mosi <= nxt_byte[7];
                    end else begin
                        if (cmd[`FSP_CMD_RD]) begin
                            rdata <= rx;
                        end
                        mosi  <= 1'b0;
                        state <= HS_TAIL;
                    end
                end
                HS_TAIL: if (half) begin
                    cs_n  <= 1'b1;
                    state <= HS_GAP;
                end
                HS_GAP: if (half) begin
                    busy  <= 1'b0;
                    state <= HS_IDLE;
                end
                default: state <= HS_IDLE;
            endcase
        end
    end

    assign link.sclk = sclk;
    assign link.cs_n = cs_n;
    assign link.mosi = mosi;
    assign link.wp_n = wp_level;

endmodule

// >>> testbench/fsp_link_chk.sv
// protection link checker
`timescale 1ns/1ps
module fsp_link_chk (
    // clock and reset
    input wire logic       CLOCK,
    input wire logic       RESETN,
    // link and device events
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       wp_n,
    input wire logic       miso_oe,
    input wire logic [7:0] STATUS_REG,
    input wire logic       OP_GRANT,
    input wire logic       OP_DENY,
    input wire logic [3:0] OP_SECTOR
);
    // ==========================================
    // link and protection properties
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    sequence decided; OP_GRANT || OP_DENY; endsequence
    sequence locked_end; $rose(cs_n) && !wp_n && STATUS_REG[7]; endsequence
    idle_clock_a: assert property (cs_n |-> !sclk) else $error("sclk idle");
    oe_off_a: assert property (cs_n [*6] |-> !miso_oe) else $error("oe idle");
    oe_on_a: assert property (!cs_n [*6] |-> miso_oe) else $error("oe sel");
    one_verdict_a: assert property (!(OP_GRANT && OP_DENY)) else $error("both verdicts");
    grant_pulse_a: assert property (OP_GRANT |=> !OP_GRANT) else $error("grant pulse");
    wel_clear_a: assert property (decided |-> ##[1:10] !STATUS_REG[1]) else $error("latch kept");
    status_lock_a: assert property (locked_end |=> $stable(STATUS_REG[7:2]) [*8]) else $error("locked");
    block_range_a: assert property (OP_GRANT |-> STATUS_REG[5:2] == 4'h0 || (STATUS_REG[5:2] < 4'h6 &&
        int'(OP_SECTOR) < 16 - (1 << (int'(STATUS_REG[5:2]) - 1)))) else $error("grant blocked");
endmodule

// >>> testbench/flash_sector_protect_and_training_tb.sv
// bench for both link ends
`timescale 1ns/1ps
`include "fsp_params.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module flash_sector_protect_and_training_tb import fsp_pkg::*; ;
    // ==========================================
    // stimulus and design
    logic        CLOCK = 1'h0, RESETN = 1'h0, PROTECT_LOCK = 1'h1, ADDR_WIDE = 1'h0;
    logic        AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
    logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00, STATUS_REG, ACTIVE_PATTERN, rd;
    logic [31:0] WDATA = 32'h0, RDATA, q;
    logic [1:0]  BRESP, RRESP, r;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, OP_GRANT, OP_DENY;
    logic [3:0]  OP_SECTOR;
    int          fail_count = 0, comparisons = 0, cycles = 0, n_grant = 0, n_deny = 0;
    localparam logic [12:0] AD = 13'h0100, WD = 13'h0200, WB = 13'h0800, RB = 13'h1000;
    fsp_link_if lnk ();
    fsp_device i_fsp_device (.CLOCK, .RESETN, .link(lnk.dev), .PROTECT_LOCK, .ADDR_WIDE,
        .STATUS_REG, .ACTIVE_PATTERN, .OP_GRANT, .OP_DENY, .OP_SECTOR);
    fsp_host i_fsp_host (.CLOCK, .RESETN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB(4'hf), .WVALID,
        .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
        .link(lnk.host));
    fsp_link_chk i_fsp_link_chk (.CLOCK, .RESETN, .sclk(lnk.sclk), .cs_n(lnk.cs_n), .wp_n(lnk.wp_n),
        .miso_oe(lnk.miso_oe), .STATUS_REG, .OP_GRANT, .OP_DENY, .OP_SECTOR);
    always #5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        cycles++;
        n_grant += OP_GRANT;
        n_deny += OP_DENY;
        if (cycles == 60000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one register bus transfer
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        if (w) begin
            {AWADDR, WDATA, AWVALID, WVALID, BREADY} <= {a, d, 3'h7};
        end else begin
            {ARADDR, ARVALID, RREADY} <= {a, 2'h3};
        end
        do begin
            @(posedge CLOCK);
            if (AWREADY) AWVALID <= 1'h0;
            if (WREADY) WVALID <= 1'h0;
            if (ARREADY) ARVALID <= 1'h0;
        end while (w ? BVALID !== 1'h1 : RVALID !== 1'h1);
        r = w ? BRESP : RRESP;
        q = RDATA;
        {BREADY, RREADY} <= 2'h0;
    endtask
    // one link frame, then its reply
    task automatic op(input logic [12:0] c, input logic [3:0] s, input logic [7:0] d);
        bus(1, `FSP_REG_ADDR, {12'h0, s, 16'h0});
        bus(1, `FSP_REG_DATA, {24'h0, d});
        bus(1, `FSP_REG_CMD, {19'h0, c});
        do bus(0, `FSP_REG_STATUS, 32'h0); while (q[0] !== 1'h0);
        bus(0, `FSP_REG_DATA, 32'h0);
        rd = q[7:0];
    endtask
    task automatic wop(logic [12:0] c, logic [3:0] s, logic [7:0] d);
        op(`FSP_OP_WRITE_ENABLE_CMD, 0, 0);
        op(c, s, d);
    endtask
    initial begin
        repeat (16) @(posedge CLOCK);
        RESETN <= 1'h1;
        bus(0, 8'h40, 32'h0);
        `CHK("unmapped", `FSP_RESP_SLVERR, r);
        op(`FSP_OP_WR_ACTIVE | WB, 0, 8'h5a);
        op(`FSP_OP_RD_PAT | RB, 0, 0);
        `CHK("pattern", 8'h5a, rd);
        `CHK("active", 8'h5a, ACTIVE_PATTERN);
        op(`FSP_OP_TRAIN_READ | AD | RB, 0, 0);
        `CHK("training", 8'h5a, rd);
        op(`FSP_OP_PG_STORED | WB, 0, 8'hc3);
        op(`FSP_OP_RD_PAT | RB, 0, 0);
        `CHK("no latch", 8'h5a, rd);
        wop(`FSP_OP_PG_STORED | WB, 0, 8'hc3);
        op(`FSP_OP_RD_PAT | RB, 0, 0);
        `CHK("copied", 8'hc3, rd);
        op(`FSP_OP_RD_DYN | AD | RB, 3, 0);
        `CHK("dyn reset", `FSP_UNPROTECTED, rd);
        wop(`FSP_OP_WR_DYN | AD | WB, 3, `FSP_PROTECTED);
        op(`FSP_OP_RD_DYN_W | AD | WD | RB, 3, 0);
        `CHK("dyn set", `FSP_PROTECTED, rd);
        wop(`FSP_OP_PROG | AD, 3, 0);
        `CHK("dyn deny", 1, n_deny);
        wop(`FSP_OP_PG_PERS | AD, 5, 0);
        wop(`FSP_OP_PG_PERS_W | AD | WD, 6, 0);
        op(`FSP_OP_RD_PERS | AD | RB, 5, 0);
        `CHK("pers set", `FSP_PROTECTED, rd);
        wop(`FSP_OP_ER_PERS, 0, 0);
        op(`FSP_OP_RD_PERS_W | AD | WD | RB, 6, 0);
        `CHK("pers erase", `FSP_UNPROTECTED, rd);
        PROTECT_LOCK <= 1'h0;
        wop(`FSP_OP_PG_PERS | AD, 5, 0);
        op(`FSP_OP_RD_PERS | AD | RB, 5, 0);
        `CHK("pers locked", `FSP_UNPROTECTED, rd);
        PROTECT_LOCK <= 1'h1;
        wop(`FSP_OP_WRSR | WB, 0, 8'h84);
        `CHK("status", 6'h21, STATUS_REG[7:2]);
        wop(`FSP_OP_PROG | AD, 15, 0);
        wop(`FSP_OP_ERASE | AD, 0, 0);
        `CHK("block deny", 2, n_deny);
        `CHK("free grant", 1, n_grant);
        bus(1, `FSP_REG_CONFIG, 32'h0);
        wop(`FSP_OP_WRSR | WB, 0, 8'h00);
        `CHK("pin guard", 6'h21, STATUS_REG[7:2]);
        bus(1, `FSP_REG_CONFIG, 32'h1);
        wop(`FSP_OP_WRSR | WB, 0, 8'h00);
        `CHK("pin high", 6'h00, STATUS_REG[7:2]);
        ADDR_WIDE <= 1'h1;
        op(`FSP_OP_RD_DYN | AD | WD | RB, 3, 0);
        `CHK("wide", `FSP_PROTECTED, rd);
        report_and_stop();
    end
endmodule
